// ===== inc/pmg_map.svh
// Notes on behaviour
// - idle enable bit passes monitor reload events
// - trap enable bit raises trap interrupt
// - input bits 21:0 read pin levels
// - input register bytes 30h-32h, read-only
// - alternate-input bits may read indeterminate values
// - output bits 30:0 drive pins, 31 reserved
// - output register reads back last written value
// - alternate function drives pin, bit kept
// - output reset pattern, pin 30 starts alternate
// - monitor control at 2Ch, resets to zero
// - interrupt only while global enable set
`ifndef PMG_MAP_SVH
`define PMG_MAP_SVH

// ----------------------------------------------------------------
// io offsets from the power-management base
// ----------------------------------------------------------------
`define PMG_DEVICE_MONITOR_CONTROL_OFS 8'h2c
`define PMG_GPI_OFS 8'h30
`define PMG_GPO_OFS 8'h34
`define PMG_LANE_MASK 8'hfc

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define PMG_DEVICE_MONITOR_CONTROL_RST 32'h0000_0000
`define PMG_DEVICE_MONITOR_CONTROL_MASK 32'h0fff_ffff
`define PMG_GPI_MASK 32'h003f_ffff
`define PMG_GPI_LANES 2'd2
`define PMG_GPO_RST 32'h07ff_bfff
`define PMG_GPO_MASK 32'h7fff_ffff
`define PMG_GPO_ALT_RST 31'h4000_0000
`define PMG_MON_IDLE_CNT 6
`define PMG_MON_TRAP_CNT 5

`endif

// ===== inc/pmg_pkg.sv
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package pmg_pkg;
  typedef logic [7:0] pmg_byte_t;
  typedef logic [31:0] pmg_word_t;
  typedef logic [1:0] pmg_lane_t;
  typedef logic [21:0] pmg_gpi_t;
  typedef logic [30:0] pmg_gpo_t;
  typedef logic [5:0] pmg_idle_t;
  typedef logic [4:0] pmg_trap_t;
endpackage

// ===== core/pmg_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module pmg_sync #(
  parameter int W = 22
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // pins and filtered level
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // stage one is read by stage two only
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree per bit
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      level_o <= '0;
    else
      level_o <= (s2_r & s3_r) | (level_o & (s2_r | s3_r));
  end
endmodule // pmg_sync

// ===== core/pmg_regs.sv
`timescale 1ns/1ps
`include "pmg_map.svh"
// ----------------------------------------------------------------
// power-management monitor control and general pin registers
// ----------------------------------------------------------------
module pmg_regs (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // io port access, byte wide
  input wire pmg_pkg::pmg_byte_t IO_ADDR_I,
  input wire logic IO_RD_I,
  input wire logic IO_WR_I,
  input wire pmg_pkg::pmg_byte_t IO_WDATA_I,
  output pmg_pkg::pmg_byte_t IO_RDATA_O,
  output logic IO_ACK_O,
  // device monitor events
  input wire pmg_pkg::pmg_idle_t MON_IDLE_EVT_I,
  input wire pmg_pkg::pmg_trap_t MON_TRAP_HIT_I,
  input wire logic GLOBAL_MGMT_IRQ_EN_I,
  output pmg_pkg::pmg_idle_t MON_IDLE_RELOAD_O,
  output pmg_pkg::pmg_trap_t MON_TRAP_SRC_O,
  output logic MGMT_IRQ_OUT_N_O,
  // general input pins
  input wire pmg_pkg::pmg_gpi_t GPI_PIN_I,
  // general output pins and alternate functions
  input wire pmg_pkg::pmg_gpo_t GPO_ALT_VAL_I,
  input wire pmg_pkg::pmg_gpo_t GPO_ALT_SEL_I,
  input wire logic GPO_ALT_LOAD_I,
  output pmg_pkg::pmg_gpo_t GPO_PIN_O
);
  import pmg_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pick one byte lane out of a word
  function automatic pmg_byte_t lane_get(input pmg_word_t w, input pmg_lane_t ln);
    pmg_byte_t b;
    b = '0;
    case (ln)
      2'd0: b = w[7:0];
      2'd1: b = w[15:8];
      2'd2: b = w[23:16];
      2'd3: b = w[31:24];
      default: b = '0;
    endcase
    return b;
  endfunction

  // replace one byte lane, leave the others as they were
  function automatic pmg_word_t lane_put(input pmg_word_t w, input pmg_lane_t ln, input pmg_byte_t b);
    pmg_word_t r;
    r = w;
    case (ln)
      2'd0: r[7:0] = b;
      2'd1: r[15:8] = b;
      2'd2: r[23:16] = b;
      2'd3: r[31:24] = b;
      default: r = w;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  pmg_lane_t lane;
  pmg_byte_t word_ofs;
  logic hit_device_monitor_control;
  logic hit_gpi;
  logic hit_gpo;

  assign lane = IO_ADDR_I[1:0];
  assign word_ofs = IO_ADDR_I & `PMG_LANE_MASK;
  assign hit_device_monitor_control = (word_ofs == `PMG_DEVICE_MONITOR_CONTROL_OFS);
  // only three bytes of the input word are decoded
  assign hit_gpi = (word_ofs == `PMG_GPI_OFS) && (lane <= `PMG_GPI_LANES);
  assign hit_gpo = (word_ofs == `PMG_GPO_OFS);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  pmg_word_t device_monitor_control_r;
  pmg_word_t device_monitor_control_nxt;
  pmg_word_t gpo_r;
  pmg_word_t gpo_nxt;
  pmg_gpo_t alt_sel_r;
  pmg_gpi_t gpi_level;

  // byte writes merge into the addressed lane only
  assign device_monitor_control_nxt = lane_put(device_monitor_control_r, lane, IO_WDATA_I) & `PMG_DEVICE_MONITOR_CONTROL_MASK;
  assign gpo_nxt = lane_put(gpo_r, lane, IO_WDATA_I) & `PMG_GPO_MASK;

  // monitor control, all enables start disabled
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      device_monitor_control_r <= `PMG_DEVICE_MONITOR_CONTROL_RST;
    else if (IO_WR_I && hit_device_monitor_control)
      device_monitor_control_r <= device_monitor_control_nxt;
  end

  // output register keeps its value even when a pin is taken over
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      gpo_r <= `PMG_GPO_RST;
    else if (IO_WR_I && hit_gpo)
      gpo_r <= gpo_nxt;
  end

  // alternate-function ownership, loaded by the pin-mux config
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      alt_sel_r <= `PMG_GPO_ALT_RST;
    else if (GPO_ALT_LOAD_I)
      alt_sel_r <= GPO_ALT_SEL_I;
  end

  // ----------------------------------------------------------------
  // input pins
  // ----------------------------------------------------------------
  // pins are asynchronous; pins muxed to another input still read
  // through here and may show noise
  pmg_sync #(
    .W(22)
  ) u_gpi_sync (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .pin_i(GPI_PIN_I),
    .level_o(gpi_level)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  pmg_byte_t rdata_nxt;

  // unmapped offsets and reserved bits read as zero
  always_comb
  begin
    rdata_nxt = '0;
    if (hit_device_monitor_control)
      rdata_nxt = lane_get(device_monitor_control_r, lane);
    else if (hit_gpi)
      rdata_nxt = lane_get({10'h000, gpi_level}, lane);
    else if (hit_gpo)
      rdata_nxt = lane_get(gpo_r, lane);
  end

  // answer one cycle after the strobe; read data holds until the next read
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      IO_RDATA_O <= '0;
      IO_ACK_O <= 1'b0;
    end
    else
    begin
      IO_ACK_O <= IO_RD_I | IO_WR_I;
      if (IO_RD_I)
        IO_RDATA_O <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  // per pin mux, registered so pins never glitch on config changes
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      GPO_PIN_O <= '0;
    else
      GPO_PIN_O <= (alt_sel_r & GPO_ALT_VAL_I) | (~alt_sel_r & gpo_r[30:0]);
  end

  // ----------------------------------------------------------------
  // device monitors
  // ----------------------------------------------------------------
  pmg_idle_t idle_en;
  pmg_trap_t trap_en;
  pmg_trap_t trap_fire;

  // even bits 0-10 enable reload, odd bits 1-9 enable trapping
  always_comb
  begin
    idle_en = '0;
    trap_en = '0;
    for (int m = 0; m < `PMG_MON_IDLE_CNT; m++)
      idle_en[m] = device_monitor_control_r[2*m];
    for (int m = 0; m < `PMG_MON_TRAP_CNT; m++)
      trap_en[m] = device_monitor_control_r[2*m+1];
  end

  assign trap_fire = MON_TRAP_HIT_I & trap_en;

  // reload strobes for the idle timers, disabled events dropped
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      MON_IDLE_RELOAD_O <= '0;
    else
      MON_IDLE_RELOAD_O <= MON_IDLE_EVT_I & idle_en;
  end

  // trap source is reported even with the global gate closed,
  // so status logic elsewhere can still record it
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      MON_TRAP_SRC_O <= '0;
    else
      MON_TRAP_SRC_O <= trap_fire;
  end

  // active-low interrupt pulse, gated by the global enable
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      MGMT_IRQ_OUT_N_O <= 1'b1;
    else
      MGMT_IRQ_OUT_N_O <= ~(|trap_fire && GLOBAL_MGMT_IRQ_EN_I);
  end
endmodule // pmg_regs

// ===== test/pmg_pins.sv
`timescale 1ns/1ps
// ----
// external pin model
// ----
module pmg_pins (
  // clock
  input wire logic clk_i,
  // wanted level and pins
  input wire pmg_pkg::pmg_gpi_t lvl_i,
  output pmg_pkg::pmg_gpi_t pin_o
);
  import pmg_pkg::*;
  // pins move after the edge so the sampler never races them
  always @(posedge clk_i)
    pin_o <= #2 lvl_i;
endmodule // pmg_pins

// ===== test/pmg_regs_chk.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module pmg_regs_chk (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // io port
  input wire pmg_pkg::pmg_byte_t IO_ADDR_I,
  input wire logic IO_RD_I,
  input wire logic IO_WR_I,
  input wire pmg_pkg::pmg_byte_t IO_RDATA_O,
  input wire logic IO_ACK_O,
  // monitors
  input wire pmg_pkg::pmg_idle_t MON_IDLE_EVT_I,
  input wire pmg_pkg::pmg_trap_t MON_TRAP_HIT_I,
  input wire logic GLOBAL_MGMT_IRQ_EN_I,
  input wire pmg_pkg::pmg_idle_t MON_IDLE_RELOAD_O,
  input wire pmg_pkg::pmg_trap_t MON_TRAP_SRC_O,
  input wire logic MGMT_IRQ_OUT_N_O
);
  import pmg_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_req;
    IO_RD_I || IO_WR_I;
  endsequence
  a_ack_follows: assert property (s_req |=> IO_ACK_O)
    else $error("ack missing");
  a_ack_only: assert property (!(IO_RD_I || IO_WR_I) |=> !IO_ACK_O)
    else $error("stray ack");
  a_rdata_holds: assert property (!IO_RD_I |=> $stable(IO_RDATA_O))
    else $error("read data moved");
  a_hole_zero: assert property (IO_RD_I && IO_ADDR_I == 8'h33 |=> IO_RDATA_O == 8'h00)
    else $error("hole byte not zero");
  a_top_rsvd: assert property (IO_RD_I && IO_ADDR_I == 8'h37 |=> !IO_RDATA_O[7])
    else $error("reserved bit set");
  a_idle_cause: assert property (1'b1 |=> (MON_IDLE_RELOAD_O & ~$past(MON_IDLE_EVT_I)) == '0)
    else $error("reload without event");
  a_trap_cause: assert property (1'b1 |=> (MON_TRAP_SRC_O & ~$past(MON_TRAP_HIT_I)) == '0)
    else $error("trap without hit");
  a_irq_gated: assert property (!GLOBAL_MGMT_IRQ_EN_I || MON_TRAP_HIT_I == '0 |=> MGMT_IRQ_OUT_N_O)
    else $error("irq while gated");
  a_irq_source: assert property (!MGMT_IRQ_OUT_N_O |-> MON_TRAP_SRC_O != '0)
    else $error("irq without source");
endmodule // pmg_regs_chk

bind pmg_regs pmg_regs_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .IO_ADDR_I(IO_ADDR_I), .IO_RD_I(IO_RD_I),
  .IO_WR_I(IO_WR_I), .IO_RDATA_O(IO_RDATA_O), .IO_ACK_O(IO_ACK_O), .MON_IDLE_EVT_I(MON_IDLE_EVT_I),
  .MON_TRAP_HIT_I(MON_TRAP_HIT_I), .GLOBAL_MGMT_IRQ_EN_I(GLOBAL_MGMT_IRQ_EN_I),
  .MON_IDLE_RELOAD_O(MON_IDLE_RELOAD_O), .MON_TRAP_SRC_O(MON_TRAP_SRC_O), .MGMT_IRQ_OUT_N_O(MGMT_IRQ_OUT_N_O));

// ===== test/pmg_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
// ----
// register slice bench
// ----
module pmg_regs_tb_top;
  import pmg_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic rd = 0;
  logic wr = 0;
  logic glb = 0;
  logic alt_ld = 0;
  logic ack;
  logic irq_n;
  pmg_byte_t addr = '0;
  pmg_byte_t wdat = '0;
  pmg_byte_t rdata;
  pmg_idle_t evt = '0;
  pmg_idle_t reload;
  pmg_trap_t hit = '0;
  pmg_trap_t trap;
  pmg_gpi_t lvl = '0;
  pmg_gpi_t general_input_bits;
  pmg_gpo_t alt_sel = '0;
  pmg_gpo_t pins;
  pmg_gpo_t alt_val = 31'h4000_1234;
  int num_errors = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  pmg_pins u_pins (.clk_i(clk), .lvl_i(lvl), .pin_o(general_input_bits));
  pmg_regs dut (.CLK_I(clk), .RST_I(rst), .IO_ADDR_I(addr), .IO_RD_I(rd), .IO_WR_I(wr), .IO_WDATA_I(wdat),
    .IO_RDATA_O(rdata), .IO_ACK_O(ack), .MON_IDLE_EVT_I(evt), .MON_TRAP_HIT_I(hit), .GLOBAL_MGMT_IRQ_EN_I(glb),
    .MON_IDLE_RELOAD_O(reload), .MON_TRAP_SRC_O(trap), .MGMT_IRQ_OUT_N_O(irq_n), .GPI_PIN_I(general_input_bits),
    .GPO_ALT_VAL_I(alt_val), .GPO_ALT_SEL_I(alt_sel), .GPO_ALT_LOAD_I(alt_ld), .GPO_PIN_O(pins));
  task end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one byte access, strobe held for exactly one sampling edge
  task acc(input pmg_byte_t a, input logic w, input pmg_byte_t d);
    int n;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
    for (n = 0; n < 4 && ack !== 1'b1; n++)
      @(posedge clk) #1;
    if (n == 4)
    begin
      num_errors++;
      end_sim;
    end
  endtask
  task rc(input pmg_byte_t a, input pmg_byte_t e);
    acc(a, 0, 8'h00);
    `CHK(rdata, e)
  endtask
  // one cycle of monitor events, outputs land a cycle later
  task ev(input pmg_idle_t i, input pmg_trap_t t, input logic g);
    @(posedge clk);
    evt <= i;
    hit <= t;
    glb <= g;
    @(posedge clk);
    evt <= '0;
    hit <= '0;
    #1;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(pins, 31'h47ff_bfff)
    rc(8'h34, 8'hff);
    rc(8'h35, 8'hbf);
    rc(8'h37, 8'h07);
    rc(8'h2c, 8'h00);
    rc(8'h2d, 8'h00);
    acc(8'h35, 1, 8'h00);
    rc(8'h34, 8'hff);
    rc(8'h35, 8'h00);
    rc(8'h36, 8'hff);
    `CHK(pins, 31'h47ff_00ff)
    acc(8'h37, 1, 8'hff);
    rc(8'h37, 8'h7f);
    @(posedge clk);
    alt_sel <= 31'h0000_00ff;
    alt_ld <= 1;
    @(posedge clk);
    alt_ld <= 0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(pins, 31'h7fff_0034)
    rc(8'h34, 8'hff);
    lvl <= 22'h2a_5c3e;
    repeat (8) @(posedge clk);
    acc(8'h30, 1, 8'h00);
    rc(8'h30, 8'h3e);
    rc(8'h31, 8'h5c);
    rc(8'h32, 8'h2a);
    rc(8'h33, 8'h00);
    acc(8'h2c, 1, 8'h55);
    acc(8'h2d, 1, 8'h05);
    ev(6'h3f, 5'h1f, 1);
    `CHK(reload, 6'h3f)
    `CHK(trap, 5'h00)
    acc(8'h2c, 1, 8'haa);
    acc(8'h2d, 1, 8'h02);
    rc(8'h2c, 8'haa);
    ev(6'h3f, 5'h1f, 1);
    `CHK(reload, 6'h00)
    `CHK(trap, 5'h1f)
    `CHK(irq_n, 1'b0)
    ev(6'h00, 5'h1f, 0);
    `CHK(irq_n, 1'b1)
    acc(8'h2c, 1, 8'h46);
    acc(8'h2d, 1, 8'h01);
    ev(6'h3f, 5'h1f, 1);
    `CHK(reload, 6'h1a)
    `CHK(trap, 5'h01)
    `CHK(irq_n, 1'b0)
    end_sim;
  end
endmodule // pmg_regs_tb_top
